/* File: design/sfr_pkg.sv */
// ----------------------------------------
// serial flash array read constants
// ----------------------------------------
package sfr_pkg;

	// read opcodes
	localparam logic [7:0] OP_CAR_HF = 8'h1B; // high frequency read
	localparam logic [7:0] OP_CAR_MF = 8'h0B; // continuous read
	localparam logic [7:0] OP_CAR_LF = 8'h03; // low frequency read
	localparam logic [7:0] OP_CAR_LP = 8'h01; // low power read
	localparam logic [7:0] OP_PAGE_RD = 8'hD2; // single page read

	// dummy bytes per opcode
	localparam logic [2:0] DUMMY_HF = 3'h2;
	localparam logic [2:0] DUMMY_MF = 3'h1;
	localparam logic [2:0] DUMMY_LF = 3'h0;
	localparam logic [2:0] DUMMY_PAGE = 3'h4;

	// serial framing
	localparam logic [2:0] LAST_BIT = 3'h7; // bit count of last bit in a byte
	localparam logic [1:0] LAST_ADDR_BYTE = 2'h2; // third address byte
	localparam logic [2:0] ONE_DUMMY = 3'h1; // last dummy byte pending

	// array address layout
	localparam int PAGE_W = 11; // page index width
	localparam int BYTE_W = 9; // byte offset width
	localparam int ARR_AW = 20; // array address width
	localparam logic [BYTE_W-1:0] LAST_BYTE_WIDE = 9'h107; // 264 byte page
	localparam logic [BYTE_W-1:0] LAST_BYTE_BIN = 9'h0FF; // 256 byte page

	// reset values
	localparam logic [23:0] ADDR_RST = 24'h000000;
	localparam logic [7:0] SHIFT_RST = 8'h00;

	// link side states
	typedef enum logic [2:0] {
		LS_OPCODE = 3'b000,
		LS_ADDR = 3'b001,
		LS_DUMMY = 3'b010,
		LS_DATA = 3'b011,
		LS_IGNORE = 3'b100
	} sfr_link_st_t;

	// fetch side states
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_ISSUE = 2'b01,
		FS_WAIT = 2'b10
	} sfr_fetch_st_t;

endpackage : sfr_pkg

/* File: design/sfr_cdc_fifo.sv */
// ----------------------------------------
// dual clock buffer, gray coded pointers
// ----------------------------------------
module sfr_cdc_fifo import sfr_pkg::*; #(
	parameter int W = 8, // word width
	parameter int AW = 1 // log2 of depth
) (
	input wire logic wclk_i,
	input wire logic wrst_i,
	input wire logic flush_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [W-1:0] wr_data_i,
	input wire logic rclk_i,
	input wire logic rrst_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [W-1:0] rd_data_o
);

	localparam int PW = AW + 1; // pointer width with wrap bit
	localparam int DEPTH = 1 << AW; // entries
	localparam logic [PW-1:0] PTR_ONE = PW'(1);
	localparam logic [PW-1:0] PTR_DEPTH = PW'(DEPTH);

	// binary to gray
	function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction : to_gray

	// gray to binary
	function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : from_gray

	// write side state
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // storage
		logic [PW-1:0] wbin; // write pointer
		logic [PW-1:0] wgray; // write pointer, gray
		logic [PW-1:0] rs1; // read pointer sync stage 1
		logic [PW-1:0] rs2; // read pointer sync stage 2
	} sfr_fw_t;

	// read side state, no write pointer stages: the link clock stops
	typedef struct packed {
		logic [PW-1:0] rbin; // read pointer
		logic [PW-1:0] rgray; // read pointer, gray
	} sfr_fr_t;

	sfr_fw_t w_ff, nxt_w;
	sfr_fr_t r_ff, nxt_r;
	logic [PW-1:0] rbin_sync; // read pointer seen by writer
	logic [PW-1:0] fill; // words held, writer view

	assign rbin_sync = from_gray(w_ff.rs2);
	assign fill = w_ff.wbin - rbin_sync;
	assign wr_ready_o = (fill != PTR_DEPTH) && !flush_i;
	// link clock stands still between bytes, so stages on it never see a new word;
	// gray pointer moves one bit per write, host pause lets it settle
	assign rd_valid_o = r_ff.rgray != w_ff.wgray;
	assign rd_data_o = w_ff.mem[r_ff.rbin[AW-1:0]];

	// write side next state
	always_comb begin
		nxt_w = w_ff;
		nxt_w.rs1 = r_ff.rgray;
		nxt_w.rs2 = w_ff.rs1;
		if (flush_i) begin
			// drop all held words
			nxt_w.wbin = rbin_sync;
			nxt_w.wgray = w_ff.rs2;
		end else if (wr_valid_i && wr_ready_o) begin
			nxt_w.mem[w_ff.wbin[AW-1:0]] = wr_data_i;
			nxt_w.wbin = w_ff.wbin + PTR_ONE;
			nxt_w.wgray = to_gray(w_ff.wbin + PTR_ONE);
		end
	end

	always_ff @(posedge wclk_i or posedge wrst_i) begin
		if (wrst_i) begin
			w_ff <= '0;
		end else begin
			w_ff <= nxt_w;
		end
	end

	// read side next state
	always_comb begin
		nxt_r = r_ff;
		if (rd_valid_o && rd_ready_i) begin
			nxt_r.rbin = r_ff.rbin + PTR_ONE;
			nxt_r.rgray = to_gray(r_ff.rbin + PTR_ONE);
		end
	end

	always_ff @(posedge rclk_i or posedge rrst_i) begin
		if (rrst_i) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

endmodule : sfr_cdc_fifo

/* File: design/sfr_array_read.sv */
module sfr_array_read import sfr_pkg::*; #(
	parameter int FIFO_AW = 1 // buffer depth is 2**FIFO_AW
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_n_o,
	input wire logic psize_256_i,
	output logic arr_rd_o,
	output logic [ARR_AW-1:0] arr_addr_o,
	input wire logic [7:0] arr_data_i,
	input wire logic arr_ack_i
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// opcode is one of the array reads
	function automatic logic op_known(input logic [7:0] op);
		return (op == OP_CAR_HF) || (op == OP_CAR_MF) || (op == OP_CAR_LF)
			|| (op == OP_CAR_LP) || (op == OP_PAGE_RD);
	endfunction : op_known

	// dummy bytes for an opcode
	function automatic logic [2:0] op_dummy(input logic [7:0] op);
		logic [2:0] n;
		n = DUMMY_LF; // 03h and 01h: none
		if (op == OP_CAR_HF) begin
			n = DUMMY_HF;
		end else if (op == OP_CAR_MF) begin
			n = DUMMY_MF;
		end else if (op == OP_PAGE_RD) begin
			n = DUMMY_PAGE;
		end
		return n;
	endfunction : op_dummy

	// split a received address into page and byte
	function automatic logic [ARR_AW-1:0] addr_split(
		input logic [23:0] a,
		input logic bin
	);
		logic [ARR_AW-1:0] r;
		if (bin) begin
			r = {a[18:8], 1'b0, a[7:0]};
		end else begin
			r = a[19:0];
		end
		return r;
	endfunction : addr_split

	// next array address after a byte
	function automatic logic [ARR_AW-1:0] addr_next(
		input logic [ARR_AW-1:0] a,
		input logic bin,
		input logic single
	);
		logic [PAGE_W-1:0] pg;
		logic [BYTE_W-1:0] by;
		logic [BYTE_W-1:0] last;
		pg = a[ARR_AW-1:BYTE_W];
		by = a[BYTE_W-1:0];
		last = bin ? LAST_BYTE_BIN : LAST_BYTE_WIDE;
		if (by >= last) begin
			by = '0;
			if (!single) begin
				pg = pg + PAGE_W'(1);
			end
		end else begin
			by = by + BYTE_W'(1);
		end
		return {pg, by};
	endfunction : addr_next

	// ----------------------------------------
	// link side state (serial clock)
	// ----------------------------------------

	// cleared whenever select is high
	typedef struct packed {
		sfr_link_st_t st; // frame phase
		logic [2:0] bit_cnt; // bit within byte
		logic [1:0] byte_cnt; // address byte count
		logic [2:0] dummy_left; // dummy bytes still due
		logic [7:0] shift; // opcode shifter
		logic dry; // current byte lost to an empty buffer
	} sfr_lnk_t;

	// survives frame end, cleared by reset only
	typedef struct packed {
		logic req_tgl; // new read request event
		logic single; // page read in this request
		logic [23:0] addr; // received address
	} sfr_hold_t;

	sfr_lnk_t lnk_ff, nxt_lnk;
	sfr_hold_t hold_ff, nxt_hold;
	logic lnk_rst; // frame reset
	logic [7:0] sh_in; // opcode with new bit
	logic last_bit; // byte completes this edge
	logic pop; // take word from buffer
	logic head_ok; // buffer word backs this byte

	// ----------------------------------------
	// fetch side state (main clock)
	// ----------------------------------------

	typedef struct packed {
		sfr_fetch_st_t st; // fetch phase
		logic [2:0] tgl_s; // request sync, stage 0 first
		logic [1:0] cs_s; // select sync
		logic [1:0] psz_s; // page layout sync
		logic bin; // binary layout of this read
		logic single; // page read wrap
		logic [ARR_AW-1:0] addr; // array address
		logic rd; // array read request
		logic flush; // empty the buffer
	} sfr_fch_t;

	sfr_fch_t f_ff, nxt_f;
	logic new_req; // request seen on main clock
	logic cs_hi; // select high, synced
	logic buf_wr_valid; // word to buffer
	logic buf_wr_ready; // buffer has room
	logic buf_rd_valid; // word waiting for link
	logic [7:0] buf_rd_data; // word at buffer head

	// ----------------------------------------
	// link side logic
	// ----------------------------------------

	// frame state clears asynchronously on select high
	assign lnk_rst = rst_i | cs_n_i;
	assign sh_in = {lnk_ff.shift[6:0], si_i};
	assign last_bit = lnk_ff.bit_cnt == LAST_BIT;

	// serial output drives only in the data phase
	assign so_oe_n_o = cs_n_i | (lnk_ff.st != LS_DATA);
	// decided at the first bit, so a late word never splits a byte
	assign head_ok = (lnk_ff.bit_cnt == 3'h0) ? buf_rd_valid : !lnk_ff.dry;
	// msb first; ones when the buffer ran dry
	assign so_o = (lnk_ff.st == LS_DATA && head_ok)
		? buf_rd_data[~lnk_ff.bit_cnt] : 1'b1;

	// link next state
	always_comb begin
		nxt_lnk = lnk_ff;
		nxt_hold = hold_ff;
		pop = 1'b0;
		nxt_lnk.bit_cnt = lnk_ff.bit_cnt + 3'h1;
		case (lnk_ff.st)
			LS_OPCODE: begin
				// collect the opcode
				nxt_lnk.shift = sh_in;
				if (last_bit) begin
					if (op_known(sh_in)) begin
						nxt_lnk.st = LS_ADDR;
						nxt_lnk.dummy_left = op_dummy(sh_in);
						nxt_hold.single = sh_in == OP_PAGE_RD;
					end else begin
						// not a read we serve
						nxt_lnk.st = LS_IGNORE;
					end
				end
			end
			LS_ADDR: begin
				// three address bytes
				nxt_hold.addr = {hold_ff.addr[22:0], si_i};
				if (last_bit) begin
					nxt_lnk.byte_cnt = lnk_ff.byte_cnt + 2'h1;
					if (lnk_ff.byte_cnt == LAST_ADDR_BYTE) begin
						// start fetch early, dummies give it time
						nxt_hold.req_tgl = !hold_ff.req_tgl;
						if (lnk_ff.dummy_left == DUMMY_LF) begin
							nxt_lnk.st = LS_DATA;
						end else begin
							nxt_lnk.st = LS_DUMMY;
						end
					end
				end
			end
			LS_DUMMY: begin
				// count dummy bytes, content ignored
				if (last_bit) begin
					nxt_lnk.dummy_left = lnk_ff.dummy_left - 3'h1;
					if (lnk_ff.dummy_left == ONE_DUMMY) begin
						nxt_lnk.st = LS_DATA;
					end
				end
			end
			LS_DATA: begin
				// remember at the first bit whether the byte has a word
				if (lnk_ff.bit_cnt == 3'h0) begin
					nxt_lnk.dry = !buf_rd_valid;
				end
				// next word after the eighth bit
				if (last_bit && head_ok) begin
					pop = 1'b1;
				end
			end
			LS_IGNORE: begin
				// wait for select to rise
				nxt_lnk.bit_cnt = lnk_ff.bit_cnt;
			end
			default: begin
				nxt_lnk.st = LS_IGNORE;
			end
		endcase
	end

	// frame state register
	always_ff @(posedge sck_i or posedge lnk_rst) begin
		if (lnk_rst) begin
			lnk_ff.st <= LS_OPCODE;
			lnk_ff.bit_cnt <= 3'h0;
			lnk_ff.byte_cnt <= 2'h0;
			lnk_ff.dummy_left <= 3'h0;
			lnk_ff.shift <= SHIFT_RST;
			lnk_ff.dry <= 1'b0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	// request hold register
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			hold_ff.req_tgl <= 1'b0;
			hold_ff.single <= 1'b0;
			hold_ff.addr <= ADDR_RST;
		end else begin
			hold_ff <= nxt_hold;
		end
	end

	// ----------------------------------------
	// fetch side logic
	// ----------------------------------------

	// stage 1 vs 2 only; stage 2 frozen while a read is open
	assign new_req = f_ff.tgl_s[2] ^ f_ff.tgl_s[1];
	assign cs_hi = f_ff.cs_s[1];
	assign arr_rd_o = f_ff.rd;
	assign arr_addr_o = f_ff.addr;
	// main array only; no buffer write path exists
	assign buf_wr_valid = (f_ff.st == FS_WAIT) && arr_ack_i && !cs_hi;

	// fetch next state
	always_comb begin
		nxt_f = f_ff;
		nxt_f.flush = 1'b0;
		nxt_f.tgl_s[0] = hold_ff.req_tgl;
		nxt_f.tgl_s[1] = f_ff.tgl_s[0];
		nxt_f.cs_s = {f_ff.cs_s[0], cs_n_i};
		nxt_f.psz_s = {f_ff.psz_s[0], psize_256_i};
		if (f_ff.st != FS_WAIT) begin
			nxt_f.tgl_s[2] = f_ff.tgl_s[1];
		end
		case (f_ff.st)
			FS_IDLE, FS_ISSUE: begin
				if (new_req) begin
					// new read: load start address, drop old words
					nxt_f.bin = f_ff.psz_s[1];
					nxt_f.single = hold_ff.single;
					nxt_f.addr = addr_split(hold_ff.addr, f_ff.psz_s[1]);
					nxt_f.flush = 1'b1;
					nxt_f.st = FS_ISSUE;
				end else if (f_ff.st == FS_ISSUE) begin
					if (cs_hi) begin
						nxt_f.st = FS_IDLE;
					end else if (buf_wr_ready && !f_ff.flush) begin
						// room for one more word
						nxt_f.rd = 1'b1;
						nxt_f.st = FS_WAIT;
					end
				end
			end
			FS_WAIT: begin
				// hold request until the array answers
				if (arr_ack_i) begin
					nxt_f.rd = 1'b0;
					nxt_f.addr = addr_next(f_ff.addr, f_ff.bin, f_ff.single);
					nxt_f.st = cs_hi ? FS_IDLE : FS_ISSUE;
				end
			end
			default: begin
				nxt_f.st = FS_IDLE;
				nxt_f.rd = 1'b0;
			end
		endcase
	end

	// fetch state register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			f_ff.st <= FS_IDLE;
			f_ff.tgl_s <= 3'h0;
			f_ff.cs_s <= 2'h3;
			f_ff.psz_s <= 2'h0;
			f_ff.bin <= 1'b0;
			f_ff.single <= 1'b0;
			f_ff.addr <= '0;
			f_ff.rd <= 1'b0;
			f_ff.flush <= 1'b0;
		end else begin
			f_ff <= nxt_f;
		end
	end

	// ----------------------------------------
	// crossing buffer, main clock to serial clock
	// ----------------------------------------

	sfr_cdc_fifo #(
		.W(8),
		.AW(FIFO_AW)
	) u_buf (
		.wclk_i(mclk_i),
		.wrst_i(rst_i),
		.flush_i(f_ff.flush),
		.wr_valid_i(buf_wr_valid),
		.wr_ready_o(buf_wr_ready),
		.wr_data_i(arr_data_i),
		.rclk_i(sck_i),
		.rrst_i(rst_i),
		.rd_valid_o(buf_rd_valid),
		.rd_ready_i(pop),
		.rd_data_o(buf_rd_data)
	);

endmodule : sfr_array_read

/* File: tb/sfr_array_read_asserts.sv */
// ----------------------------------------
// port checker for the array read block
// ----------------------------------------
module sfr_array_read_asserts import sfr_pkg::*; #(
	parameter int FIFO_AW = 1 // buffer depth exponent
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic so_o,
	input wire logic so_oe_n_o,
	input wire logic psize_256_i,
	input wire logic arr_rd_o,
	input wire logic [ARR_AW-1:0] arr_addr_o,
	input wire logic [7:0] arr_data_i,
	input wire logic arr_ack_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [ARR_AW-1:0] last_ff; // last answered address
	logic have_ff; // an answer seen in this frame
	logic [BYTE_W-1:0] lastb; // last byte of a page
	// remember answered address while selected
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			last_ff <= '0;
			have_ff <= 1'b0;
		end else begin
			if (arr_ack_i && arr_rd_o && !cs_n_i) begin
				last_ff <= arr_addr_o;
			end
			have_ff <= cs_n_i ? 1'b0 : (have_ff | (arr_ack_i & arr_rd_o));
		end
	end
	assign lastb = psize_256_i ? LAST_BYTE_BIN : LAST_BYTE_WIDE;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_open;
		$fell(cs_n_i);
	endsequence
	sequence s_taken;
		arr_rd_o && arr_ack_i;
	endsequence
	a_cs_floats: assert property (cs_n_i |-> so_oe_n_o)
		else $error("output driven while deselected");
	a_header_floats: assert property (s_open |-> so_oe_n_o [*4])
		else $error("output driven during header");
	a_idle_high: assert property (so_oe_n_o |-> so_o)
		else $error("idle output not high");
	a_rd_holds: assert property (arr_rd_o && !arr_ack_i |=> arr_rd_o && $stable(arr_addr_o))
		else $error("request dropped before answer");
	a_rd_drops: assert property (s_taken |=> !arr_rd_o)
		else $error("request not dropped after answer");
	a_stop_fetch: assert property (cs_n_i [*4] |-> !$rose(arr_rd_o))
		else $error("fetch started while deselected");
	a_rst_quiet: assert property ($fell(rst_i) |-> so_oe_n_o && !arr_rd_o && arr_addr_o == '0)
		else $error("outputs active after reset");
	a_addr_step: assert property ($rose(arr_rd_o) && have_ff |->
		((last_ff[8:0] >= lastb) ? (arr_addr_o[8:0] == 9'h000 &&
		(arr_addr_o[19:9] == last_ff[19:9] || arr_addr_o[19:9] == last_ff[19:9] + 11'h001))
		: (arr_addr_o == last_ff + 20'h00001)))
		else $error("array address not sequential");
endmodule : sfr_array_read_asserts

bind sfr_array_read sfr_array_read_asserts #(.FIFO_AW(FIFO_AW)) u_chk (.mclk_i, .rst_i,
	.sck_i, .cs_n_i, .si_i, .so_o, .so_oe_n_o, .psize_256_i, .arr_rd_o, .arr_addr_o,
	.arr_data_i, .arr_ack_i);

/* File: tb/sfr_spi_host.sv */
// ----------------------------------------
// host controller model, mode 0
// ----------------------------------------
module sfr_spi_host (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_n_i
);
	timeunit 1ns;
	timeprecision 100ps;
	int oe_errs; // wrong enable samples
	logic [7:0] rx_q[$]; // bytes read back
	// clock stands low outside frames
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b1;
		oe_errs = 0;
	end
	// one bit: data set on falling, sampled before rising
	task automatic bit_cycle(input logic b, input logic oe, output logic s);
		si_o = b;
		#7.5;
		s = so_i;
		if (so_oe_n_i !== oe) oe_errs++;
		sck_o = 1'b1;
		#7.5;
		sck_o = 1'b0;
	endtask : bit_cycle
	// whole frame, select held low throughout
	task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nd,
		input int nb, input logic oe);
		logic [31:0] hdr;
		logic [7:0] b;
		logic s;
		hdr = {op, addr};
		rx_q.delete();
		cs_n_o = 1'b0;
		for (int i = 31; i >= 0; i--) bit_cycle(hdr[i], 1'b1, s);
		for (int i = 0; i < 8 * nd; i++) bit_cycle(~si_o, 1'b1, s);
		for (int n = 0; n < nb; n++) begin
			#1500;
			for (int i = 7; i >= 0; i--) bit_cycle(~si_o, oe, b[i]);
			rx_q.push_back(b);
		end
		#20;
		cs_n_o = 1'b1;
	endtask : frame
endmodule : sfr_spi_host

/* File: tb/sfr_array_read_bench.sv */
// ----------------------------------------
// self checking bench for array reads
// ----------------------------------------
module sfr_array_read_bench import sfr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i, rst_i, sck_i, cs_n_i, si_i, so_o, so_oe_n_o, psize_256_i;
	logic arr_rd_o, arr_ack_i;
	logic [ARR_AW-1:0] arr_addr_o;
	logic [7:0] arr_data_i;
	int failures, n_tests;
	logic [31:0] seed, r;
	logic [8:0] by;
	logic [7:0] ops [5] = '{OP_CAR_HF, OP_CAR_MF, OP_CAR_LF, OP_CAR_LP, OP_PAGE_RD};
	int dums [5] = '{2, 1, 0, 0, 4};
	sfr_array_read #(.FIFO_AW(1)) dut (.mclk_i, .rst_i, .sck_i, .cs_n_i, .si_i, .so_o,
		.so_oe_n_o, .psize_256_i, .arr_rd_o, .arr_addr_o, .arr_data_i, .arr_ack_i);
	sfr_spi_host host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o),
		.so_oe_n_i(so_oe_n_o));
	always #50 mclk_i = ~mclk_i;
	// array contents as a function of address
	function automatic logic [7:0] mem(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
	endfunction : mem
	// next address of the stream
	function automatic logic [19:0] step(input logic [19:0] a, input logic bin,
		input logic one);
		logic [10:0] pg;
		logic [8:0] b;
		pg = a[19:9];
		b = a[8:0];
		if (b >= (bin ? 9'h0FF : 9'h107)) begin
			b = 9'h000;
			if (!one) pg = pg + 11'h001;
		end else begin
			b = b + 9'h001;
		end
		return {pg, b};
	endfunction : step
	// array side: random latency, changing data between answers
	always @(negedge mclk_i) begin
		if (arr_rd_o && !arr_ack_i && ($random(seed) & 32'h3) != 32'h3) begin
			arr_ack_i <= 1'b1;
			arr_data_i <= mem(arr_addr_o);
		end else begin
			arr_ack_i <= 1'b0;
			arr_data_i <= ~arr_data_i;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one read frame and its comparison
	task automatic run(input logic [7:0] op, input int nd, input logic bin,
		input logic [10:0] pg, input logic [8:0] b, input int nb);
		logic [19:0] a;
		logic [23:0] sent;
		@(negedge mclk_i);
		psize_256_i = bin;
		repeat (6) @(negedge mclk_i);
		a = bin ? {pg, 1'b0, b[7:0]} : {pg, b};
		sent = bin ? {5'h00, pg, b[7:0]} : {4'h0, pg, b};
		host.frame(op, sent, nd, nb, 1'b0);
		#1;
		check({7'h00, so_oe_n_o}, 8'h01);
		for (int i = 0; i < nb; i++) begin
			check(host.rx_q[i], mem(a));
			a = step(a, bin, op == OP_PAGE_RD);
		end
		check({7'h00, host.oe_errs != 0}, 8'h00);
		$display("test done: op %h layout %0d", op, bin);
	endtask : run
	task automatic report_and_stop();
		$display("comparisons %0d, wrong %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	// main sequence
	initial begin
		seed = 32'h339ccbd2;
		mclk_i = 1'b0;
		rst_i = 1'b1;
		psize_256_i = 1'b0;
		arr_ack_i = 1'b0;
		arr_data_i = 8'h00;
		failures = 0;
		n_tests = 0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_i = 1'b0;
		for (int k = 0; k < 10; k++) begin
			r = $random(seed);
			by = (r[8:0] > 9'h107) ? r[8:0] - 9'h108 : r[8:0];
			run(ops[k % 5], dums[k % 5], k[0], r[19:9], by, 3);
		end
		run(OP_CAR_MF, 1, 1'b0, 11'h123, 9'h106, 3);
		run(OP_CAR_HF, 2, 1'b1, 11'h045, 9'h0FE, 3);
		run(OP_CAR_LF, 0, 1'b0, 11'h7FF, 9'h106, 3);
		run(OP_CAR_LP, 0, 1'b1, 11'h7FF, 9'h0FF, 2);
		run(OP_PAGE_RD, 4, 1'b0, 11'h3A5, 9'h107, 2);
		run(OP_PAGE_RD, 4, 1'b1, 11'h2B0, 9'h0FE, 3);
		// unknown opcode: output stays floating and high
		repeat (6) @(negedge mclk_i);
		host.frame(8'h5A, 24'h012345, 0, 1, 1'b1);
		check(host.rx_q[0], 8'hFF);
		check({7'h00, host.oe_errs != 0}, 8'h00);
		$display("test done: unknown opcode");
		report_and_stop();
	end
	// watchdog well past the expected run length
	initial begin
		#300000;
		failures++;
		report_and_stop();
	end
endmodule : sfr_array_read_bench
